// ---- dv/epiu_asserts.sv ----
// Purpose: Port checks of the pin interrupt unit
// Assumes: Full variant, one clock
// Notes: Shadows sense and enable writes
`default_nettype none
module epiu_asserts
  import epiu_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic ext_irq_pin,
  input wire logic global_irq_enable,
  input wire logic io_clock_run,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic [30:0] pin_change_inputs,
  input wire logic [3:0] pc_group_ack,
  input wire logic ext_irq_request,
  input wire logic pc_group0_request,
  input wire logic pc_group1_request,
  input wire logic pc_group3_request
);
  logic [1:0] sense_q;
  logic [7:0] en_q;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  always_ff @(posedge clock) begin
    if (!nrst) sense_q <= 2'h0;
    else if (wr_en && addr == EPIU_ADDR_SENSE) sense_q <= wdata[1:0];
  end
  always_ff @(posedge clock) begin
    if (!nrst) en_q <= 8'h00;
    else if (wr_en && addr == EPIU_ADDR_ENABLE) en_q <= wdata;
  end
  ext_gate_a:
    assert property (ext_irq_request |-> $past(global_irq_enable) && $past(en_q[0])) else $error("pin ungated");
  pc0_gate_a:
    assert property (pc_group0_request |-> $past(global_irq_enable) && $past(en_q[4])) else $error("g0 ungated");
  pc1_gate_a:
    assert property (pc_group1_request |-> $past(en_q[5])) else $error("g1 ungated");
  ack_clear_a:
    assert property ($stable(pin_change_inputs)[*4] ##0 pc_group_ack[3] |-> ##2 !pc_group3_request)
      else $error("ack kept request");
  level_req_a:
    assert property ((sense_q == EPIU_SENSE_LOW && en_q[0] && global_irq_enable && !ext_irq_pin)[*5]
      |-> ext_irq_request) else $error("level request missing");
  io_stop_a:
    assert property ((!io_clock_run && $stable(en_q) && $stable(global_irq_enable))[*6] ##0 sense_q[1]
      |-> !$rose(ext_irq_request)) else $error("edge seen while stopped");
  flag_rsvd_a:
    assert property (rd_en && addr == EPIU_ADDR_FLAGS |=> rdata[3:1] == 3'h0) else $error("reserved flags set");
  level_flag_a:
    assert property ((sense_q == EPIU_SENSE_LOW)[*2] ##0 (rd_en && addr == EPIU_ADDR_FLAGS) |=> !rdata[0])
      else $error("pin flag in level mode");
endmodule
`default_nettype wire

// ---- dv/epiu_cpu.sv ----
// Purpose: Processor side entering handlers
// Assumes: Entry one cycle after a request
// Notes: Enters only while auto_ack is high
`default_nettype none
module epiu_cpu (
  input wire logic clock,
  input wire logic nrst,
  input wire logic auto_ack,
  input wire logic [4:0] req,
  output logic [4:0] ack_q
);
  logic [4:0] ack_d1_q;
  always_ff @(posedge clock) begin
    ack_q <= (nrst && auto_ack) ? req & ~ack_q & ~ack_d1_q : 5'h00;
  end
  always_ff @(posedge clock) begin
    ack_d1_q <= ack_q;
  end
endmodule
`default_nettype wire

// ---- dv/epiu_tb.sv ----
// Purpose: Register and pin tests of the pin interrupt unit
// Assumes: Full variant
// Notes: Pins toggled by the bench
`default_nettype none
module epiu_tb
  import epiu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, nrst = 1'b0, wr_en = 1'b0, rd_en = 1'b0, ext_irq_pin = 1'b1;
  logic global_irq_enable = 1'b1, io_clock_run = 1'b1, auto_ack = 1'b0, ext_irq_request, wake_request;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [7:0] regs [8] = '{EPIU_ADDR_FLAGS, EPIU_ADDR_SENSE, EPIU_ADDR_ENABLE, EPIU_ADDR_PCM0,
    EPIU_ADDR_PCM1, EPIU_ADDR_PCM2, EPIU_ADDR_PCM3, 8'h00};
  logic [30:0] pin_change_inputs = 31'h0000_0000;
  logic [4:0] ack;
  logic [3:0] req_pc;
  int failures = 0;
  int samples_checked = 0;
  always #5 clock = ~clock;
  epiu_top i_epiu_top (.clock, .nrst, .addr, .wdata, .wr_en, .rd_en, .rdata, .ext_irq_pin, .pin_change_inputs,
    .global_irq_enable, .io_clock_run, .ext_irq_ack(ack[0]), .pc_group_ack(ack[4:1]), .ext_irq_request,
    .pc_group0_request(req_pc[0]), .pc_group1_request(req_pc[1]), .pc_group2_request(req_pc[2]),
    .pc_group3_request(req_pc[3]), .wake_request);
  epiu_cpu i_epiu_cpu (.clock, .nrst, .auto_ack, .req({req_pc, ext_irq_request}), .ack_q(ack));
  task automatic test_done;
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  initial begin
    pause(20);
    nrst <= 1'b1;
    pause(3);
    for (int i = 0; i < 8; i++) rd(regs[i], 8'h00);
    for (int g = 0; g < 4; g++) begin
      wr(EPIU_ADDR_ENABLE, 8'h10 << g);
      wr(regs[3 + g], 8'h01);
      pin_change_inputs[g * 8 + 1] <= ~pin_change_inputs[g * 8 + 1];
      pause(5);
      rd(EPIU_ADDR_FLAGS, 8'h00);
      pin_change_inputs[g * 8] <= ~pin_change_inputs[g * 8];
      pause(5);
      chk({4'h0, req_pc}, 8'h01 << g);
      rd(EPIU_ADDR_FLAGS, 8'h10 << g);
      wr(EPIU_ADDR_FLAGS, 8'h10 << g);
      rd(EPIU_ADDR_FLAGS, 8'h00);
    end
    auto_ack <= 1'b1;
    pin_change_inputs[24] <= ~pin_change_inputs[24];
    pause(8);
    rd(EPIU_ADDR_FLAGS, 8'h00);
    auto_ack <= 1'b0;
    wr(EPIU_ADDR_ENABLE, 8'h01);
    for (int m = 1; m < 4; m++) begin
      wr(EPIU_ADDR_SENSE, m[7:0]);
      ext_irq_pin <= 1'b0;
      pause(5);
      rd(EPIU_ADDR_FLAGS, {7'h00, m != 3});
      wr(EPIU_ADDR_FLAGS, 8'h01);
      ext_irq_pin <= 1'b1;
      pause(5);
      rd(EPIU_ADDR_FLAGS, {7'h00, m != 2});
      wr(EPIU_ADDR_FLAGS, 8'h01);
    end
    global_irq_enable <= 1'b0;
    wr(EPIU_ADDR_SENSE, {6'h00, EPIU_SENSE_FALL});
    ext_irq_pin <= 1'b0;
    pause(5);
    chk({7'h00, ext_irq_request}, 8'h00);
    rd(EPIU_ADDR_FLAGS, 8'h01);
    wr(EPIU_ADDR_FLAGS, 8'h01);
    ext_irq_pin <= 1'b1;
    global_irq_enable <= 1'b1;
    io_clock_run <= 1'b0;
    pause(3);
    ext_irq_pin <= 1'b0;
    pause(5);
    rd(EPIU_ADDR_FLAGS, 8'h00);
    wr(EPIU_ADDR_SENSE, {6'h00, EPIU_SENSE_LOW});
    pause(5);
    chk({6'h00, ext_irq_request, wake_request}, 8'h03);
    rd(EPIU_ADDR_FLAGS, 8'h00);
    ext_irq_pin <= 1'b1;
    pause(5);
    chk({6'h00, ext_irq_request, wake_request}, 8'h00);
    test_done;
  end
  initial begin
    repeat (3000) @(posedge clock);
    failures++;
    test_done;
  end
endmodule
bind epiu_top epiu_asserts i_epiu_asserts (.clock, .nrst, .wr_en, .rd_en, .ext_irq_pin, .global_irq_enable,
  .io_clock_run, .addr, .wdata, .rdata, .pin_change_inputs, .pc_group_ack, .ext_irq_request,
  .pc_group0_request, .pc_group1_request, .pc_group3_request);
`default_nettype wire

// ---- hdl/epiu_pkg.sv ----
// Purpose: Constants for the external pin interrupt unit
// Assumes: 8-bit register port, byte-wide offsets
// Notes: Offsets other than the pending flags are free placements
`default_nettype none
package epiu_pkg;
  localparam logic [7:0] EPIU_ADDR_FLAGS = 8'h1c;
  localparam logic [7:0] EPIU_ADDR_SENSE = 8'h69;
  localparam logic [7:0] EPIU_ADDR_ENABLE = 8'h1d;
  localparam logic [7:0] EPIU_ADDR_PCM0 = 8'h6b;
  localparam logic [7:0] EPIU_ADDR_PCM1 = 8'h6c;
  localparam logic [7:0] EPIU_ADDR_PCM2 = 8'h6d;
  localparam logic [7:0] EPIU_ADDR_PCM3 = 8'h6e;
  localparam logic [7:0] EPIU_RESET_VAL = 8'h00;
  localparam int EPIU_BIT_EXT = 0;
  localparam int EPIU_BIT_G0 = 4;
  localparam int EPIU_NGROUPS = 4;
  localparam logic [1:0] EPIU_SENSE_LOW = 2'h0;
  localparam logic [1:0] EPIU_SENSE_ANY = 2'h1;
  localparam logic [1:0] EPIU_SENSE_FALL = 2'h2;
  localparam logic [1:0] EPIU_SENSE_RISE = 2'h3;
  localparam logic [7:0] EPIU_FLAG_MASK_FULL = 8'hf1;
  localparam logic [7:0] EPIU_FLAG_MASK_SMALL = 8'h31;
  localparam logic [7:0] EPIU_PCM3_MASK = 8'h7f;
endpackage
`default_nettype wire

// ---- hdl/epiu_top.sv ----
// Purpose: External pin and pin-change interrupt detection with flags and requests
// Assumes: Pins are asynchronous; software uses a one-cycle strobe register port
// Notes: Handler entry is signalled by per-source acknowledge pulses
//
// Design decision made here: the address-and-strobe port.
`default_nettype none
module epiu_top
  import epiu_pkg::*;
#(
  parameter bit FULL_VARIANT = 1'b1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic ext_irq_pin,
  input wire logic [30:0] pin_change_inputs,
  input wire logic global_irq_enable,
  input wire logic io_clock_run,
  input wire logic ext_irq_ack,
  input wire logic [3:0] pc_group_ack,
  output logic ext_irq_request,
  output logic pc_group0_request,
  output logic pc_group1_request,
  output logic pc_group2_request,
  output logic pc_group3_request,
  output logic wake_request
);

  // ****************************************
  // Registers
  // ****************************************
  logic [1:0] sense_q;
  logic [7:0] enable_q;
  logic ext_pin_flag_q;
  logic pc_group0_flag_q;
  logic pc_group1_flag_q;
  logic pc_group2_flag_q;
  logic pc_group3_flag_q;
  logic [7:0] flags_all;
  logic [7:0] pc_pin_mask_g0_q;
  logic [7:0] pc_pin_mask_g1_q;
  logic [7:0] pc_pin_mask_g2_q;
  logic [7:0] pc_pin_mask_g3_q;
  logic [7:0] flag_mask;
  logic wr_flags;

  // Write strobe aimed at one register
  function automatic logic wr_hit(input logic we, input logic [7:0] a, input logic [7:0] target);
    wr_hit = we && (a == target);
  endfunction

  assign flag_mask = FULL_VARIANT ? EPIU_FLAG_MASK_FULL : EPIU_FLAG_MASK_SMALL;
  assign wr_flags = wr_hit(wr_en, addr, EPIU_ADDR_FLAGS);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sense_q <= EPIU_SENSE_LOW;
    end else if (wr_hit(wr_en, addr, EPIU_ADDR_SENSE)) begin
      sense_q <= wdata[1:0];
    end
  end

  // Reserved enable bits stay zero on the small variant
  always_ff @(posedge clock) begin
    if (!nrst) begin
      enable_q <= EPIU_RESET_VAL;
    end else if (wr_hit(wr_en, addr, EPIU_ADDR_ENABLE)) begin
      enable_q <= wdata & flag_mask;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pc_pin_mask_g0_q <= EPIU_RESET_VAL;
    end else if (wr_hit(wr_en, addr, EPIU_ADDR_PCM0)) begin
      pc_pin_mask_g0_q <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pc_pin_mask_g1_q <= EPIU_RESET_VAL;
    end else if (wr_hit(wr_en, addr, EPIU_ADDR_PCM1)) begin
      pc_pin_mask_g1_q <= wdata;
    end
  end

  // Masks 2 and 3 exist only on the full variant
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pc_pin_mask_g2_q <= EPIU_RESET_VAL;
    end else if (wr_hit(wr_en, addr, EPIU_ADDR_PCM2)) begin
      pc_pin_mask_g2_q <= FULL_VARIANT ? wdata : EPIU_RESET_VAL;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pc_pin_mask_g3_q <= EPIU_RESET_VAL;
    end else if (wr_hit(wr_en, addr, EPIU_ADDR_PCM3)) begin
      pc_pin_mask_g3_q <= FULL_VARIANT ? (wdata & EPIU_PCM3_MASK) : EPIU_RESET_VAL;
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Pins are read as inputs regardless of direction, so driven outputs still trigger
  logic ext_meta_q, ext_sync_q, ext_prev_q;
  logic [30:0] pc_meta_q, pc_sync_q, pc_prev_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ext_meta_q <= 1'b1;
      ext_sync_q <= 1'b1;
      ext_prev_q <= 1'b1;
    end else begin
      ext_meta_q <= ext_irq_pin;
      ext_sync_q <= ext_meta_q;
      // Tracked while stopped too, so a restart shows no stale edge
      ext_prev_q <= ext_sync_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pc_meta_q <= 31'h0000_0000;
      pc_sync_q <= 31'h0000_0000;
      pc_prev_q <= 31'h0000_0000;
    end else begin
      pc_meta_q <= pin_change_inputs;
      pc_sync_q <= pc_meta_q;
      pc_prev_q <= pc_sync_q;
    end
  end

  // ****************************************
  // Event detection
  // ****************************************
  logic ext_event;
  logic [3:0] pc_event;
  logic [31:0] pc_toggle;
  logic [31:0] pc_mask_all;
  logic level_low;

  function automatic logic group_hit(input logic [7:0] tog, input logic [7:0] msk, input logic en);
    group_hit = en && |(tog & msk);
  endfunction

  assign level_low = (sense_q == EPIU_SENSE_LOW) && !ext_sync_q;

  always_comb begin
    ext_event = 1'b0;
    if (io_clock_run) begin
      unique case (sense_q)
        EPIU_SENSE_LOW: ext_event = 1'b0;
        EPIU_SENSE_ANY: ext_event = ext_sync_q ^ ext_prev_q;
        EPIU_SENSE_FALL: ext_event = ext_prev_q && !ext_sync_q;
        EPIU_SENSE_RISE: ext_event = !ext_prev_q && ext_sync_q;
      endcase
    end
  end

  assign pc_toggle = {1'b0, pc_sync_q ^ pc_prev_q};
  assign pc_mask_all = {pc_pin_mask_g3_q, pc_pin_mask_g2_q, pc_pin_mask_g1_q, pc_pin_mask_g0_q};

  always_comb begin
    for (int g = 0; g < EPIU_NGROUPS; g++) begin
      pc_event[g] = group_hit(pc_toggle[g*8 +: 8], pc_mask_all[g*8 +: 8], enable_q[EPIU_BIT_G0+g]);
    end
  end

  // ****************************************
  // Pending flags
  // ****************************************
  // Set wins over a clear in the same cycle
  function automatic logic flag_clr(input logic ack, input logic wr, input logic wbit);
    flag_clr = ack || (wr && wbit);
  endfunction

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ext_pin_flag_q <= 1'b0;
    end else if (sense_q == EPIU_SENSE_LOW) begin
      ext_pin_flag_q <= 1'b0;
    end else if (ext_event) begin
      ext_pin_flag_q <= 1'b1;
    end else if (flag_clr(ext_irq_ack, wr_flags, wdata[EPIU_BIT_EXT])) begin
      ext_pin_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pc_group0_flag_q <= 1'b0;
    end else if (!flag_mask[EPIU_BIT_G0]) begin
      pc_group0_flag_q <= 1'b0;
    end else if (pc_event[0]) begin
      pc_group0_flag_q <= 1'b1;
    end else if (flag_clr(pc_group_ack[0], wr_flags, wdata[EPIU_BIT_G0])) begin
      pc_group0_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pc_group1_flag_q <= 1'b0;
    end else if (!flag_mask[EPIU_BIT_G0+1]) begin
      pc_group1_flag_q <= 1'b0;
    end else if (pc_event[1]) begin
      pc_group1_flag_q <= 1'b1;
    end else if (flag_clr(pc_group_ack[1], wr_flags, wdata[EPIU_BIT_G0+1])) begin
      pc_group1_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pc_group2_flag_q <= 1'b0;
    end else if (!flag_mask[EPIU_BIT_G0+2]) begin
      pc_group2_flag_q <= 1'b0;
    end else if (pc_event[2]) begin
      pc_group2_flag_q <= 1'b1;
    end else if (flag_clr(pc_group_ack[2], wr_flags, wdata[EPIU_BIT_G0+2])) begin
      pc_group2_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pc_group3_flag_q <= 1'b0;
    end else if (!flag_mask[EPIU_BIT_G0+3]) begin
      pc_group3_flag_q <= 1'b0;
    end else if (pc_event[3]) begin
      pc_group3_flag_q <= 1'b1;
    end else if (flag_clr(pc_group_ack[3], wr_flags, wdata[EPIU_BIT_G0+3])) begin
      pc_group3_flag_q <= 1'b0;
    end
  end

  assign flags_all = {pc_group3_flag_q, pc_group2_flag_q, pc_group1_flag_q, pc_group0_flag_q, 3'h0, ext_pin_flag_q};

  // ****************************************
  // Requests and wake
  // ****************************************
  // Wake is decoded from the raw pins and registered once, so it works while io_clock_run is low
  logic [30:0] pc_async_diff;
  logic async_wake;
  assign pc_async_diff = (pin_change_inputs ^ pc_sync_q) & pc_mask_all[30:0];
  assign async_wake = |pc_async_diff || (enable_q[EPIU_BIT_EXT] && (sense_q == EPIU_SENSE_LOW) && !ext_irq_pin);

  function automatic logic req_gate(input logic glb, input logic en, input logic flag);
    req_gate = glb && en && flag;
  endfunction

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ext_irq_request <= 1'b0;
    end else begin
      // Level request only while pin is still low at this edge
      ext_irq_request <= req_gate(global_irq_enable, enable_q[EPIU_BIT_EXT],
                                  ext_pin_flag_q || level_low);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pc_group0_request <= 1'b0;
    end else begin
      pc_group0_request <= req_gate(global_irq_enable, enable_q[EPIU_BIT_G0], pc_group0_flag_q);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pc_group1_request <= 1'b0;
    end else begin
      pc_group1_request <= req_gate(global_irq_enable, enable_q[EPIU_BIT_G0+1], pc_group1_flag_q);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pc_group2_request <= 1'b0;
    end else begin
      pc_group2_request <= req_gate(global_irq_enable, enable_q[EPIU_BIT_G0+2], pc_group2_flag_q);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pc_group3_request <= 1'b0;
    end else begin
      pc_group3_request <= req_gate(global_irq_enable, enable_q[EPIU_BIT_G0+3], pc_group3_flag_q);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= async_wake;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    unique case (a)
      EPIU_ADDR_FLAGS: read_mux = flags_all & flag_mask;
      EPIU_ADDR_SENSE: read_mux = {6'h00, sense_q};
      EPIU_ADDR_ENABLE: read_mux = enable_q;
      EPIU_ADDR_PCM0: read_mux = pc_pin_mask_g0_q;
      EPIU_ADDR_PCM1: read_mux = pc_pin_mask_g1_q;
      EPIU_ADDR_PCM2: read_mux = pc_pin_mask_g2_q;
      EPIU_ADDR_PCM3: read_mux = pc_pin_mask_g3_q;
      default: read_mux = 8'h00;
    endcase
  endfunction

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      rdata <= read_mux(addr);
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire
